// ===== hdl/jtsm_consts.vh
/*
 * constants for the test access port controller: state codes, instruction
 * codes, widths and the capture pattern.
 * assumes it is included by bare name after the guard below.
 */
// How it works
// [RULE1] sixteen states, advance on tck rise by tms
// [RULE2] five tms-high rises always reach reset
// [RULE3] reset state: test logic idle, stays on tms
// [RULE4] reset loads the identification instruction
// [RULE5] power-up starts in test-logic-reset
// [RULE6] idle holds on low tms, high to select-dr
// [RULE7] select-dr: low to capture-dr, high select-ir
// [RULE8] capture-dr samples pins for extest/sample
// [RULE9] capture-dr: high exit1-dr, low shift-dr
// [RULE10] shift-dr moves selected register toward tdo
// [RULE11] exit1-dr: high update-dr, low pause-dr
// [RULE12] pause-dr holds shift, high to exit2-dr
// [RULE13] exit2-dr: high update-dr, low shift-dr
// [RULE14] update-dr latches boundary output on falling tck
// [RULE15] select-ir: low capture-ir, high to reset
// [RULE16] capture-ir loads fixed pattern 100
// [RULE17] capture-ir: high exit1-ir, low shift-ir
// [RULE18] shift-ir moves instruction shifter toward tdo
// [RULE19] other states keep instruction and data
// [RULE20] exit1-ir: high update-ir, low pause-ir
// [RULE21] pause-ir holds shift, high to exit2-ir
// [RULE22] exit2-ir: high update-ir, low shift-ir
// [RULE23] update-ir latches instruction on falling tck
// [RULE24] reset/update states: low idle; update high select-dr
// [RULE25] tdo changes on falling tck, driven when shifting
`ifndef JTSM_CONSTS_VH
`define JTSM_CONSTS_VH

// ========================================================
// one-hot state codes
`define JTSM_ST_RESET 16'h0001
`define JTSM_ST_IDLE 16'h0002
`define JTSM_ST_SEL_DR 16'h0004
`define JTSM_ST_CAP_DR 16'h0008
`define JTSM_ST_SH_DR 16'h0010
`define JTSM_ST_EX1_DR 16'h0020
`define JTSM_ST_PAU_DR 16'h0040
`define JTSM_ST_EX2_DR 16'h0080
`define JTSM_ST_UPD_DR 16'h0100
`define JTSM_ST_SEL_IR 16'h0200
`define JTSM_ST_CAP_IR 16'h0400
`define JTSM_ST_SH_IR 16'h0800
`define JTSM_ST_EX1_IR 16'h1000
`define JTSM_ST_PAU_IR 16'h2000
`define JTSM_ST_EX2_IR 16'h4000
`define JTSM_ST_UPD_IR 16'h8000

// ========================================================
// widths, instructions and patterns
`define JTSM_IR_W 3
`define JTSM_BSR_W 8
`define JTSM_IR_CAPTURE 3'h4
`define JTSM_INS_EXTEST 3'h0
`define JTSM_INS_SAMPLE 3'h1
`define JTSM_INS_IDCODE 3'h2
`define JTSM_INS_BYPASS 3'h7
`define JTSM_ID_W 32
`define JTSM_ID_VALUE 32'h00000001

`endif

// ===== hdl/jtsm_sync.v
/*
 * two-flop synchroniser for one level from outside the clock domain.
 * assumes sys clock and an already synchronised active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module jtsm_sync (
   // clock and reset
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire ce_i,
   // level
   input wire d_i,
   output wire q_o
);
   reg meta_reg;
   reg sync_reg;

   // ========================================================
   // first flop feeds only the second
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else if (ce_i) begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;
endmodule
`default_nettype wire

// ===== hdl/jtsm_tap.v
/*
 * test access port controller: sixteen-state machine, instruction register,
 * bypass, identification and boundary scan registers, tdo driver.
 * assumes tck, tms and tdi come from an outside tester, slow against sys_clk_i,
 * and are sampled here; tck edges are found on the synchronised copy.
 */
`include "jtsm_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module jtsm_tap (
   // clock, reset, enable
   input wire sys_clk_i,
   input wire nrst_i,
   input wire ce_i,
   // tester pins
   input wire tck_i,
   input wire tms_i,
   input wire tdi_i,
   output reg tdo_o,
   output reg tdo_oe_o,
   // device pins seen by the boundary register
   input wire [`JTSM_BSR_W-1:0] pins_i,
   output reg [`JTSM_BSR_W-1:0] bsr_par_o,
   // status
   output wire test_active_o,
   output wire [`JTSM_IR_W-1:0] instr_o,
   output wire [15:0] state_o
);
   reg rst_m_reg;
   reg rst_n_reg;
   wire tck_s;
   wire tms_s;
   wire tdi_s;
   reg tck_d_reg;
   reg [15:0] state_reg;
   reg [15:0] state_next;
   reg [`JTSM_IR_W-1:0] ir_sh_reg;
   reg [`JTSM_IR_W-1:0] ir_reg;
   reg [`JTSM_BSR_W-1:0] bsr_sh_reg;
   reg [`JTSM_ID_W-1:0] id_sh_reg;
   reg byp_reg;
   reg tdo_next;
   wire tck_rise;
   wire tck_fall;
   wire sel_bsr;
   wire sel_id;

   // ========================================================
   // reset release through two flops
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_m_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_m_reg <= 1'b1;
         rst_n_reg <= rst_m_reg;
      end
   end

   // ========================================================
   // pin synchronisers
   jtsm_sync u_sync_tck (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_reg),
      .ce_i(ce_i),
      .d_i(tck_i),
      .q_o(tck_s)
   );
   jtsm_sync u_sync_tms (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_reg),
      .ce_i(ce_i),
      .d_i(tms_i),
      .q_o(tms_s)
   );
   jtsm_sync u_sync_tdi (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_reg),
      .ce_i(ce_i),
      .d_i(tdi_i),
      .q_o(tdi_s)
   );

   // edge detection on synchronised tck
   always @(posedge sys_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         tck_d_reg <= 1'b0;
      end else if (ce_i) begin
         tck_d_reg <= tck_s;
      end
   end
   assign tck_rise = tck_s & ~tck_d_reg;
   assign tck_fall = ~tck_s & tck_d_reg;

   // ========================================================
   // next state by tms at tck rise
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `JTSM_ST_RESET: begin
            state_next = tms_s ? `JTSM_ST_RESET : `JTSM_ST_IDLE; // [RULE3] [RULE24]
         end
         `JTSM_ST_IDLE: begin
            state_next = tms_s ? `JTSM_ST_SEL_DR : `JTSM_ST_IDLE; // [RULE6]
         end
         `JTSM_ST_SEL_DR: begin
            state_next = tms_s ? `JTSM_ST_SEL_IR : `JTSM_ST_CAP_DR; // [RULE7]
         end
         `JTSM_ST_CAP_DR: begin
            state_next = tms_s ? `JTSM_ST_EX1_DR : `JTSM_ST_SH_DR; // [RULE9]
         end
         `JTSM_ST_SH_DR: begin
            state_next = tms_s ? `JTSM_ST_EX1_DR : `JTSM_ST_SH_DR; // [RULE10]
         end
         `JTSM_ST_EX1_DR: begin
            state_next = tms_s ? `JTSM_ST_UPD_DR : `JTSM_ST_PAU_DR; // [RULE11]
         end
         `JTSM_ST_PAU_DR: begin
            state_next = tms_s ? `JTSM_ST_EX2_DR : `JTSM_ST_PAU_DR; // [RULE12]
         end
         `JTSM_ST_EX2_DR: begin
            state_next = tms_s ? `JTSM_ST_UPD_DR : `JTSM_ST_SH_DR; // [RULE13]
         end
         `JTSM_ST_UPD_DR: begin
            state_next = tms_s ? `JTSM_ST_SEL_DR : `JTSM_ST_IDLE; // [RULE24]
         end
         `JTSM_ST_SEL_IR: begin
            state_next = tms_s ? `JTSM_ST_RESET : `JTSM_ST_CAP_IR; // [RULE15]
         end
         `JTSM_ST_CAP_IR: begin
            state_next = tms_s ? `JTSM_ST_EX1_IR : `JTSM_ST_SH_IR; // [RULE17]
         end
         `JTSM_ST_SH_IR: begin
            state_next = tms_s ? `JTSM_ST_EX1_IR : `JTSM_ST_SH_IR; // [RULE18]
         end
         `JTSM_ST_EX1_IR: begin
            state_next = tms_s ? `JTSM_ST_UPD_IR : `JTSM_ST_PAU_IR; // [RULE20]
         end
         `JTSM_ST_PAU_IR: begin
            state_next = tms_s ? `JTSM_ST_EX2_IR : `JTSM_ST_PAU_IR; // [RULE21]
         end
         `JTSM_ST_EX2_IR: begin
            state_next = tms_s ? `JTSM_ST_UPD_IR : `JTSM_ST_SH_IR; // [RULE22]
         end
         `JTSM_ST_UPD_IR: begin
            state_next = tms_s ? `JTSM_ST_SEL_DR : `JTSM_ST_IDLE; // [RULE24]
         end
         default: begin
            state_next = `JTSM_ST_RESET; // illegal code recovers to reset
         end
      endcase
   end

   // state register; five high tms rises reach reset from anywhere
   always @(posedge sys_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= `JTSM_ST_RESET; // [RULE5]
      end else if (ce_i && tck_rise) begin
         state_reg <= state_next; // [RULE1] [RULE2]
      end
   end

   // ========================================================
   // register selection by current instruction
   assign sel_bsr = (ir_reg == `JTSM_INS_EXTEST) || (ir_reg == `JTSM_INS_SAMPLE);
   assign sel_id = (ir_reg == `JTSM_INS_IDCODE);

   // shift paths act on tck rise; other states hold their values
   always @(posedge sys_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ir_sh_reg <= `JTSM_IR_CAPTURE;
         bsr_sh_reg <= {`JTSM_BSR_W{1'b0}};
         id_sh_reg <= {`JTSM_ID_W{1'b0}};
         byp_reg <= 1'b0;
      end else if (ce_i && tck_rise) begin
         if (state_reg == `JTSM_ST_CAP_IR) begin
            ir_sh_reg <= `JTSM_IR_CAPTURE; // [RULE16]
         end else if (state_reg == `JTSM_ST_SH_IR) begin
            ir_sh_reg <= {tdi_s, ir_sh_reg[`JTSM_IR_W-1:1]}; // [RULE18]
         end
         if (state_reg == `JTSM_ST_CAP_DR) begin
            if (sel_bsr) begin
               bsr_sh_reg <= pins_i; // [RULE8]
            end
            if (sel_id) begin
               id_sh_reg <= `JTSM_ID_VALUE;
            end
            byp_reg <= 1'b0;
         end else if (state_reg == `JTSM_ST_SH_DR) begin
            if (sel_bsr) begin
               bsr_sh_reg <= {tdi_s, bsr_sh_reg[`JTSM_BSR_W-1:1]}; // [RULE10]
            end else if (sel_id) begin
               id_sh_reg <= {tdi_s, id_sh_reg[`JTSM_ID_W-1:1]}; // [RULE10]
            end else begin
               byp_reg <= tdi_s;
            end
         end
         // pause, exit, select and update states leave shifters alone [RULE19]
      end
   end

   // ========================================================
   // falling tck: updates and tdo
   always @* begin
      tdo_next = byp_reg;
      if (state_reg == `JTSM_ST_SH_IR) begin
         tdo_next = ir_sh_reg[0];
      end else if (sel_bsr) begin
         tdo_next = bsr_sh_reg[0];
      end else if (sel_id) begin
         tdo_next = id_sh_reg[0];
      end
   end

   always @(posedge sys_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ir_reg <= `JTSM_INS_IDCODE;
         bsr_par_o <= {`JTSM_BSR_W{1'b0}};
         tdo_o <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else if (ce_i) begin
         if (state_reg == `JTSM_ST_RESET) begin
            ir_reg <= `JTSM_INS_IDCODE; // [RULE4]
         end else if (tck_fall && state_reg == `JTSM_ST_UPD_IR) begin
            ir_reg <= ir_sh_reg; // [RULE23]
         end
         if (tck_fall && state_reg == `JTSM_ST_UPD_DR && sel_bsr) begin
            bsr_par_o <= bsr_sh_reg; // [RULE14]
         end
         if (tck_fall) begin
            tdo_oe_o <= (state_reg == `JTSM_ST_SH_DR) || (state_reg == `JTSM_ST_SH_IR); // [RULE25]
            tdo_o <= tdo_next; // [RULE25]
         end
      end
   end

   // status outputs
   assign test_active_o = (state_reg != `JTSM_ST_RESET); // [RULE3]
   assign instr_o = ir_reg;
   assign state_o = state_reg;
endmodule
`default_nettype wire

// ===== tb/jtsm_tap_sva.sv
/*
 * checker for the tap controller ports.
 * assumes one clock domain and tck slow against sys_clk_i.
 */
`include "jtsm_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module jtsm_tap_sva (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // tester pins
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   input wire logic tdo_o,
   input wire logic tdo_oe_o,
   // device side
   input wire logic [7:0] pins_i,
   input wire logic [7:0] bsr_par_o,
   input wire logic test_active_o,
   input wire logic [2:0] instr_o,
   input wire logic [15:0] state_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   // =====
   // a step of the machine away from a given state
   sequence s_left(logic [15:0] st);
      $changed(state_o) && $past(state_o) == st;
   endsequence
   property p_onehot; $onehot(state_o); endproperty
   a_onehot: assert property (p_onehot) else $error("state not one-hot");
   property p_active; test_active_o == (state_o != `JTSM_ST_RESET); endproperty
   a_active: assert property (p_active) else $error("active flag wrong");
   property p_ir_rst; $past(state_o) == `JTSM_ST_RESET && state_o == `JTSM_ST_RESET |-> instr_o == `JTSM_INS_IDCODE;
   endproperty
   a_ir_rst: assert property (p_ir_rst) else $error("reset instruction wrong");
   property p_oe_on; $rose(tdo_oe_o) |-> state_o inside {`JTSM_ST_SH_DR, `JTSM_ST_SH_IR}; endproperty
   a_oe_on: assert property (p_oe_on) else $error("tdo driven outside shift");
   property p_oe_off; tdo_oe_o && !(state_o inside {`JTSM_ST_SH_DR, `JTSM_ST_SH_IR}) |-> ##[1:12] !tdo_oe_o;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("tdo not released");
   property p_bsr; $changed(bsr_par_o) |-> state_o == `JTSM_ST_UPD_DR; endproperty
   a_bsr: assert property (p_bsr) else $error("parallel output moved");
   property p_instr; $changed(instr_o) |-> state_o inside {`JTSM_ST_UPD_IR, `JTSM_ST_RESET}
      || $past(state_o) == `JTSM_ST_RESET; endproperty
   a_instr: assert property (p_instr) else $error("instruction moved");
   property p_idle; s_left(`JTSM_ST_IDLE) |-> state_o == `JTSM_ST_SEL_DR; endproperty
   a_idle: assert property (p_idle) else $error("bad exit from idle");
   property p_capdr; s_left(`JTSM_ST_CAP_DR) |-> state_o inside {`JTSM_ST_EX1_DR, `JTSM_ST_SH_DR}; endproperty
   a_capdr: assert property (p_capdr) else $error("bad exit from capture-dr");
   property p_selir; s_left(`JTSM_ST_SEL_IR) |-> state_o inside {`JTSM_ST_CAP_IR, `JTSM_ST_RESET}; endproperty
   a_selir: assert property (p_selir) else $error("bad exit from select-ir");
   property p_capir; s_left(`JTSM_ST_CAP_IR) |-> state_o inside {`JTSM_ST_EX1_IR, `JTSM_ST_SH_IR}; endproperty
   a_capir: assert property (p_capir) else $error("bad exit from capture-ir");
endmodule
`default_nettype wire

// ===== tb/jtsm_tester.sv
/*
 * boundary-scan tester model driving tck, tms and tdi.
 * assumes tdo_i is the wire level with its pull-up applied.
 */
`timescale 1ns/10ps
`default_nettype none
module jtsm_tester (
   // pacing clock
   input wire logic sys_clk_i,
   // test pins
   input wire logic tdo_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   // tck stands low between cycles
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   // one 900 ns tck cycle: pins move while tck is low, tdo taken at the rise
   task automatic xfer(input logic tms, input logic tdi, output logic tdo);
      @(negedge sys_clk_i);
      tms_o = tms;
      tdi_o = tdi;
      repeat (4) @(negedge sys_clk_i);
      tck_o = 1'b1;
      tdo = tdo_i;
      repeat (4) @(negedge sys_clk_i);
      tck_o = 1'b0;
      tdi_o = ~tdi; // tdi hold is over
   endtask
endmodule
`default_nettype wire

// ===== tb/test_jtag_tap_state_machine.sv
/*
 * self-checking bench for the tap controller with a reference model.
 * assumes the tester model and the checker beside it.
 */
`include "jtsm_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module test_jtag_tap_state_machine;
   logic sys_clk_i = 1'b0;
   logic nrst_i, tck, tms, tdi, tdo_o, tdo_oe_o, test_active_o, tdo_line, seen;
   logic [7:0] pins_i, bsr_par_o, bsr_sh, bsr_par;
   logic [2:0] instr_o, ir_sh, ins;
   logic [15:0] state_o;
   logic [31:0] dr;
   int err_total, samples_checked, st, seed;
   int n0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
   int n1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
   logic [2:0] codes[5] = '{`JTSM_INS_EXTEST, `JTSM_INS_SAMPLE, `JTSM_INS_IDCODE, `JTSM_INS_BYPASS, 3'h5};
   // clock and pulled-up tdo wire
   always #50 sys_clk_i = ~sys_clk_i;
   assign tdo_line = tdo_oe_o ? tdo_o : 1'b1;
   jtsm_tap jtsm_tap_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .tck_i(tck), .tms_i(tms),
      .tdi_i(tdi), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pins_i(pins_i), .bsr_par_o(bsr_par_o),
      .test_active_o(test_active_o), .instr_o(instr_o), .state_o(state_o));
   jtsm_tester jtsm_tester_i (.sys_clk_i(sys_clk_i), .tdo_i(tdo_line), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
   // =====
   // compare and verdict
   task automatic chk(input string name, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, e, s);
      end
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one tck cycle through design and model
   task automatic step(input logic t, input logic di);
      logic bs, id, e;
      bs = ins == `JTSM_INS_EXTEST || ins == `JTSM_INS_SAMPLE;
      id = ins == `JTSM_INS_IDCODE;
      e = st == 11 ? ir_sh[0] : (bs ? bsr_sh[0] : dr[0]);
      jtsm_tester_i.xfer(t, di, seen);
      if (st == 4 || st == 11) chk("tdo", seen, e);
      case (st)
         3: if (bs) bsr_sh = pins_i; else dr = id ? `JTSM_ID_VALUE : 32'h0;
         4: if (bs) bsr_sh = {di, bsr_sh[7:1]}; else dr = id ? {di, dr[31:1]} : {31'h0, di};
         10: ir_sh = `JTSM_IR_CAPTURE;
         11: ir_sh = {di, ir_sh[2:1]};
         default: ;
      endcase
      st = t ? n1[st] : n0[st];
      if (st == 15) ins = ir_sh;
      if (st == 8 && bs) bsr_par = bsr_sh;
      if (st == 0) ins = `JTSM_INS_IDCODE;
      repeat (5) @(negedge sys_clk_i);
      chk("state", state_o, 16'h0001 << st);
      chk("instr", instr_o, ins);
      chk("bsr_par", bsr_par_o, bsr_par);
   endtask
   // full scan from idle back to idle
   task automatic scan(input logic ir, input logic [39:0] v, input int n);
      step(1, 1'b0);
      if (ir) step(1, 1'b0);
      step(0, 1'b0);
      step(0, 1'b0);
      for (int i = 0; i < n; i++) step(i == n - 1, v[i]);
      step(1, 1'b0);
      step(0, 1'b0);
   endtask
   // watchdog
   initial begin
      #5000000;
      err_total++;
      test_done();
   end
   // main sequence
   initial begin
      nrst_i = 1'b0;
      pins_i = 8'h00;
      {err_total, samples_checked, st, dr, bsr_sh, bsr_par, ir_sh} = '0;
      ins = `JTSM_INS_IDCODE;
      seed = $urandom(32'h16b5d04d);
      repeat (10) @(negedge sys_clk_i);
      nrst_i = 1'b1;
      repeat (5) @(negedge sys_clk_i);
      chk("state", state_o, `JTSM_ST_RESET);
      chk("active", test_active_o, 1'b0);
      step(1, 1'b1);
      step(0, 1'b0);
      step(0, 1'b1);
      foreach (codes[k]) begin
         scan(1, {37'h0, codes[k]}, 3);
         pins_i = 8'($urandom);
         scan(0, 40'({$urandom, $urandom}), 40);
      end
      repeat (300) begin
         pins_i = 8'($urandom);
         step(1'($urandom), 1'($urandom));
      end
      repeat (8) begin
         repeat ($urandom % 6) step(1'($urandom), 1'($urandom));
         repeat (5) step(1'b1, 1'($urandom));
         chk("reset", state_o, `JTSM_ST_RESET);
      end
      test_done();
   end
endmodule
bind jtsm_tap jtsm_tap_sva jtsm_tap_sva_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .tck_i(tck_i),
   .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pins_i(pins_i), .bsr_par_o(bsr_par_o),
   .test_active_o(test_active_o), .instr_o(instr_o), .state_o(state_o));
`default_nettype wire
